// ---- lsd_seg_timing.sv ----
// LCD segment driver core: clock select, frame timing, cascade sync, 32x4 display RAM,
// mode dependent byte packing, data pointer and subaddress counter, output multiplexing.
// Assumes one AHB-Lite master as the command source and a clock that never stops.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_defines.svh"

module lsd_seg_timing #(
  parameter int OSC_HALF = `LSD_OSC_HALF_DEF
) (
  input  wire logic        REF_CLK,    // 20 MHz system clock
  input  wire logic        RSTN,       // Async reset, active low
  input  wire logic        HSEL,       // AHB select
  input  wire logic [31:0] HADDR,      // AHB address
  input  wire logic [1:0]  HTRANS,     // AHB transfer type
  input  wire logic        HWRITE,     // AHB write
  input  wire logic [2:0]  HSIZE,      // AHB size, word only
  input  wire logic [31:0] HWDATA,     // AHB write data
  input  wire logic        HREADY,     // AHB bus ready
  output logic             HREADYOUT,  // AHB slave ready
  output logic [31:0]      HRDATA,     // AHB read data
  output logic             HRESP,      // AHB response, always OKAY
  input  wire logic        OSC_SEL,    // Oscillator select pin
  input  wire logic        CLK_I,      // Clock line, input side
  output logic             CLK_O,      // Clock line, output side
  output logic             CLK_OE_N,   // Clock line drive enable, low drives
  input  wire logic        SYNC_I,     // Cascade sync, input side
  output logic             SYNC_O,     // Cascade sync, output side
  output logic             SYNC_OE_N,  // Cascade sync drive enable, low drives
  input  wire logic [2:0]  HW_SUBADDR, // Hardware subaddress straps
  output logic [3:0]       BP,         // Backplane activity
  output logic [31:0]      SEG,        // Segment on states
  output logic             FRAME_TICK  // One pulse per frame
);

  // Pin synchronisers: stage 1 feeds only stage 2
  logic       osc_m, osc_s;
  logic       clk_m, clk_s, clk_d;
  logic       sync_m, sync_s, sync_d;
  logic [2:0] strap_m, strap_s;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      osc_m   <= 1'b0;
      osc_s   <= 1'b0;
      clk_m   <= 1'b0;
      clk_s   <= 1'b0;
      clk_d   <= 1'b0;
      sync_m  <= 1'b1;
      sync_s  <= 1'b1;
      sync_d  <= 1'b1;
      strap_m <= 3'h0;
      strap_s <= 3'h0;
    end else begin
      osc_m   <= OSC_SEL;
      osc_s   <= osc_m;
      clk_m   <= CLK_I;
      clk_s   <= clk_m;
      clk_d   <= clk_s;
      sync_m  <= SYNC_I;
      sync_s  <= sync_m;
      sync_d  <= sync_s;
      strap_m <= HW_SUBADDR;
      strap_s <= strap_m;
    end
  end

  // Internal oscillator stands in as a divided square wave of REF_CLK
  logic [15:0] osc_cnt;
  logic        osc_rise;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      osc_cnt  <= 16'h0000;
      CLK_O    <= 1'b0;
      osc_rise <= 1'b0;
    end else if (osc_cnt == 16'(OSC_HALF - 1)) begin
      osc_cnt  <= 16'h0000;
      CLK_O    <= ~CLK_O;
      osc_rise <= ~CLK_O;
    end else begin
      osc_cnt  <= osc_cnt + 16'h0001;
      osc_rise <= 1'b0;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      CLK_OE_N <= 1'b1;
    end else begin
      CLK_OE_N <= osc_s; // RULE_01 RULE_02
    end
  end

  // One enable per rising edge of whichever clock is selected
  logic clk_tick;
  assign clk_tick = osc_s ? (clk_s & ~clk_d) : osc_rise; // RULE_01

  // Register state
  lsd_pkg::lsd_mode_e mode;
  logic               disp_en;
  logic [4:0]         ptr;
  logic [2:0]         sub;
  logic [3:0]         ram [0:31];

  // Frame counter and cascade alignment
  logic [4:0] frame_cnt;
  logic       sync_fall;
  assign sync_fall = sync_d & ~sync_s;

  // Own drive delayed like the line input, so our own falling edge never restarts us
  logic       sync_oe_q1, sync_oe_q2;

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      sync_oe_q1 <= 1'b1;
      sync_oe_q2 <= 1'b1;
    end else begin
      sync_oe_q1 <= SYNC_OE_N;
      sync_oe_q2 <= sync_oe_q1;
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      frame_cnt <= 5'h00;
    end else if (sync_fall && sync_oe_q2) begin
      // Another device started its frame; restart ours to match
      frame_cnt <= 5'h00; // RULE_04
    end else if (clk_tick) begin
      frame_cnt <= (frame_cnt == `LSD_FRAME_LAST) ? 5'h00 : frame_cnt + 5'h01; // RULE_03
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SYNC_O     <= 1'b0;
      SYNC_OE_N  <= 1'b1;
      FRAME_TICK <= 1'b0;
    end else begin
      SYNC_O     <= 1'b0;
      SYNC_OE_N  <= (frame_cnt != 5'h00); // RULE_04
      FRAME_TICK <= clk_tick && (frame_cnt == `LSD_FRAME_LAST); // RULE_03
    end
  end

  // Active row for the frame position: 24 ticks split evenly over the rows
  function automatic logic [1:0] row_of(input lsd_pkg::lsd_mode_e m, input logic [4:0] c);
    logic [1:0] r;
    r = 2'h0;
    case (m)
      lsd_pkg::LSD_STATIC: r = 2'h0;
      lsd_pkg::LSD_MUX2:   r = (c >= 5'd12) ? 2'h1 : 2'h0;
      lsd_pkg::LSD_MUX3:   r = (c >= 5'd16) ? 2'h2 : (c >= 5'd8) ? 2'h1 : 2'h0;
      lsd_pkg::LSD_MUX4:   r = (c >= 5'd18) ? 2'h3 : (c >= 5'd12) ? 2'h2 :
                               (c >= 5'd6) ? 2'h1 : 2'h0;
      default:             r = 2'h0;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] bp_of(input lsd_pkg::lsd_mode_e m, input logic [1:0] r);
    logic [3:0] b;
    b = 4'h0;
    case (m)
      lsd_pkg::LSD_STATIC: b = 4'hF;                                      // RULE_07
      lsd_pkg::LSD_MUX2:   b = r[0] ? 4'hA : 4'h5;                        // RULE_06
      lsd_pkg::LSD_MUX3:   b = (r == 2'h0) ? 4'h1 : (r == 2'h1) ? 4'hA : 4'h4; // RULE_05
      lsd_pkg::LSD_MUX4:   b = 4'(4'h1 << r);
      default:             b = 4'h0;
    endcase
    return b;
  endfunction

  logic [1:0]         row;
  lsd_pkg::lsd_mode_e out_mode;
  assign row = row_of(mode, frame_cnt);

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      BP       <= 4'h0;
      SEG      <= 32'h0000_0000;
      out_mode <= lsd_pkg::LSD_MUX4;
    end else begin
      out_mode <= mode;
      BP       <= disp_en ? bp_of(mode, row) : 4'h0; // RULE_08
      for (int c = 0; c < 32; c++) begin
        SEG[c] <= disp_en & ram[c][row]; // RULE_08 RULE_09
      end
    end
  end

  // AHB-Lite slave: zero wait states, read data registered in the address phase
  logic       ap_valid;
  logic       dp_wr;
  logic [7:0] dp_addr;
  assign ap_valid = HSEL && HREADY && HTRANS[1];

  function automatic logic [31:0] rd_mux(input logic [7:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    case (a)
      `LSD_OFS_CTRL:   d = {29'h0, disp_en, mode};
      `LSD_OFS_DPTR:   d = {27'h0, ptr};
      `LSD_OFS_DEVSEL: d = {29'h0, sub};
      `LSD_OFS_STATUS: d = {21'h0, frame_cnt, row, strap_s, osc_s};
      default:         d = 32'h0000_0000;
    endcase
    return d;
  endfunction

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      dp_wr     <= 1'b0;
      dp_addr   <= 8'h00;
      HRDATA    <= 32'h0000_0000;
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
    end else begin
      HREADYOUT <= 1'b1;
      HRESP     <= 1'b0;
      if (HREADY) begin
        dp_wr   <= ap_valid && HWRITE;
        dp_addr <= HADDR[7:0];
      end
      if (ap_valid && !HWRITE) begin
        HRDATA <= rd_mux(HADDR[7:0]);
      end
    end
  end

  logic wr_ctrl, wr_dptr, wr_dev, wr_data;
  assign wr_ctrl = dp_wr && (dp_addr == `LSD_OFS_CTRL);
  assign wr_dptr = dp_wr && (dp_addr == `LSD_OFS_DPTR);
  assign wr_dev  = dp_wr && (dp_addr == `LSD_OFS_DEVSEL);
  assign wr_data = dp_wr && (dp_addr == `LSD_OFS_DATA);

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      mode    <= lsd_pkg::LSD_MUX4;
      disp_en <= `LSD_RST_EN;
    end else if (wr_ctrl) begin
      mode    <= lsd_pkg::lsd_mode_e'(HWDATA[`LSD_CTRL_MODE_HI:`LSD_CTRL_MODE_LO]);
      disp_en <= HWDATA[`LSD_CTRL_EN_BIT];
    end
  end

  // Packing of byte bit p (0 = MSB) into column offset and row
  function automatic logic [2:0] col_off(input lsd_pkg::lsd_mode_e m, input logic [2:0] p);
    logic [2:0] o;
    o = 3'h0;
    case (m)
      lsd_pkg::LSD_STATIC: o = p;
      lsd_pkg::LSD_MUX2:   o = {1'b0, p[2:1]};
      lsd_pkg::LSD_MUX3:   o = (p >= 3'd6) ? 3'h2 : (p >= 3'd3) ? 3'h1 : 3'h0;
      lsd_pkg::LSD_MUX4:   o = {2'b00, p[2]};
      default:             o = 3'h0;
    endcase
    return o;
  endfunction

  function automatic logic [1:0] row_in(input lsd_pkg::lsd_mode_e m, input logic [2:0] p);
    logic [1:0] r;
    r = 2'h0;
    case (m)
      lsd_pkg::LSD_STATIC: r = 2'h0;
      lsd_pkg::LSD_MUX2:   r = {1'b0, p[0]};
      lsd_pkg::LSD_MUX3:   r = (p >= 3'd6) ? 2'(p - 3'd6) : (p >= 3'd3) ? 2'(p - 3'd3) : p[1:0];
      lsd_pkg::LSD_MUX4:   r = p[1:0];
      default:             r = 2'h0;
    endcase
    return r;
  endfunction

  function automatic logic [3:0] ptr_inc(input lsd_pkg::lsd_mode_e m);
    logic [3:0] i;
    i = 4'h2;
    case (m)
      lsd_pkg::LSD_STATIC: i = 4'h8;
      lsd_pkg::LSD_MUX2:   i = 4'h4;
      lsd_pkg::LSD_MUX3:   i = 4'h3;
      lsd_pkg::LSD_MUX4:   i = 4'h2;
      default:             i = 4'h2;
    endcase
    return i;
  endfunction

  logic       sub_match;
  logic [5:0] ptr_sum;
  assign sub_match = (sub == strap_s);                         // RULE_17
  assign ptr_sum   = {1'b0, ptr} + {2'b00, ptr_inc(mode)};     // RULE_15

  // Display RAM; in three-backplane mode row 3 and the last row-2 slot are never touched
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      for (int c = 0; c < 32; c++) begin
        ram[c] <= 4'h0;
      end
    end else if (wr_data && sub_match) begin // RULE_17 RULE_18
      for (int p = 0; p < 8; p++) begin
        // RULE_10 RULE_11 RULE_12 RULE_13 RULE_14 RULE_24
        ram[5'(ptr + {2'b00, col_off(mode, 3'(p))})][row_in(mode, 3'(p))] <= HWDATA[7 - p];
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ptr <= `LSD_RST_PTR; // RULE_23
      sub <= `LSD_RST_SUB; // RULE_23
    end else begin
      if (wr_dptr) begin
        ptr <= HWDATA[4:0]; // RULE_14
      end else if (wr_data) begin
        ptr <= ptr_sum[4:0]; // RULE_15 RULE_18 RULE_25
      end
      if (wr_dev) begin
        sub <= HWDATA[2:0]; // RULE_19
      end else if (wr_data && ptr_sum[5]) begin
        sub <= sub + 3'h1; // RULE_19 RULE_25
      end
    end
  end

  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RSTN);

  a_clk_drive_int: assert property (osc_s == 1'b0 |=> CLK_OE_N == 1'b0) // RULE_02
    else $error("clock line not driven with internal oscillator");
  a_clk_ext_in: assert property (osc_s |=> CLK_OE_N && (clk_tick == (clk_s & ~clk_d))) // RULE_01
    else $error("external clock not used as input");
  a_frame_wrap: assert property (clk_tick && frame_cnt == `LSD_FRAME_LAST && !sync_fall // RULE_03
                                 |=> frame_cnt == 5'h00 ##1 FRAME_TICK == 1'b0)
    else $error("frame did not wrap after 24 ticks");
  a_sync_drive: assert property (frame_cnt == 5'h00 |=> !SYNC_OE_N) // RULE_04
    else $error("sync not driven at frame start");
  a_bp_mux3: assert property (out_mode == lsd_pkg::LSD_MUX3 |-> BP[3] == BP[1]) // RULE_05
    else $error("backplane 3 differs from 1");
  a_bp_mux2: assert property (out_mode == lsd_pkg::LSD_MUX2 |-> BP[2] == BP[0] && BP[3] == BP[1]) // RULE_06
    else $error("backplane pairs differ");
  a_bp_static: assert property (out_mode == lsd_pkg::LSD_STATIC |-> BP == 4'h0 || BP == 4'hF) // RULE_07
    else $error("static backplanes differ");
  a_seg_map: assert property (disp_en |=> SEG[0] == $past(ram[0][row])) // RULE_09
    else $error("segment 0 does not follow RAM");
  a_ptr_adv: assert property (wr_data |=> ptr == $past(ptr_sum[4:0])) // RULE_15
    else $error("pointer did not advance by mode step");
  a_sub_wrap: assert property (wr_data && ptr_sum[5] && !wr_dev |=> sub == 3'($past(sub) + 3'h1)) // RULE_19
    else $error("subaddress counter did not follow overflow");
  a_store_msb: assert property (wr_data && sub_match && mode == lsd_pkg::LSD_MUX4 // RULE_24
                                |=> ram[$past(ptr)] == {$past(HWDATA[4]), $past(HWDATA[5]),
                                                        $past(HWDATA[6]), $past(HWDATA[7])})
    else $error("first column not loaded MSB first");
  a_no_store: assert property (wr_data && !sub_match |=> ram[$past(ptr)] == $past(ram[ptr])) // RULE_18
    else $error("byte stored on subaddress mismatch");
  a_sync_restart: assert property (sync_fall && sync_oe_q2 |=> frame_cnt == 5'h00) // RULE_04
    else $error("frame not realigned by foreign sync edge");
  a_bp_mux4: assert property (out_mode == lsd_pkg::LSD_MUX4 |-> BP == 4'h0 || $onehot(BP)) // RULE_08
    else $error("four-backplane rows overlap");
  a_store_static: assert property (wr_data && sub_match && mode == lsd_pkg::LSD_STATIC // RULE_10
                                   |=> ram[$past(ptr)][0] == $past(HWDATA[7]))
    else $error("static byte MSB not in row 0");
  a_store_mux2: assert property (wr_data && sub_match && mode == lsd_pkg::LSD_MUX2 // RULE_11
                                 |=> ram[$past(ptr)][1:0] ==
                                     {$past(HWDATA[6]), $past(HWDATA[7])})
    else $error("two-backplane byte not MSB first");
  a_store_mux3: assert property (wr_data && sub_match && mode == lsd_pkg::LSD_MUX3 // RULE_12
                                 |=> ram[$past(ptr)][2:0] ==
                                     {$past(HWDATA[5]), $past(HWDATA[6]), $past(HWDATA[7])})
    else $error("three-backplane byte not MSB first");

  c_mux3_store: cover property (wr_data && sub_match && mode == lsd_pkg::LSD_MUX3);
  c_ptr_overflow: cover property (wr_data && ptr_sum[5]);
  c_frame_end: cover property (FRAME_TICK);
  c_sync_align: cover property (sync_fall && sync_oe_q2);
  c_ext_tick: cover property (osc_s && clk_tick);

endmodule
`default_nettype wire

// ---- lsd_defines.svh ----
// Constants for the LCD segment RAM and timing block: offsets, fields, resets, timing.
// Assumes inclusion by bare name from the design file; definitions only.
// Operation
// RULE_01 - Oscillator-select low: internal clock, high: external
// RULE_02 - Internal clock selected: drive clock line out
// RULE_03 - Frame frequency is selected clock over 24
// RULE_04 - Cascade sync line keeps multiplex timing aligned
// RULE_05 - Three-backplane mode: backplane 3 copies backplane 1
// RULE_06 - Two-backplane mode: 0/2 and 1/3 identical
// RULE_07 - Static mode: all four backplanes identical
// RULE_08 - Segments follow RAM in backplane sequence
// RULE_09 - Column is segment, row is backplane, 1=on
// RULE_10 - Static: byte into row 0, eight columns
// RULE_11 - Two-backplane: four 2-bit words, rows 0-1
// RULE_12 - Three-backplane: three 3-bit words, last bit kept
// RULE_13 - Four-backplane: two 4-bit words, rows 0-3
// RULE_14 - Pointer load sets column of next byte
// RULE_15 - Pointer advances 8, 4, 3 or 2 per byte
// RULE_16 - Host reloads pointer after aborted transfer
// RULE_17 - Store only when subaddress counter equals straps
// RULE_18 - Mismatch: discard byte, still advance pointer
// RULE_19 - Device-select loads counter; pointer overflow increments it
// RULE_20 - Host selects and loads pointer per device
// RULE_21 - System keeps a clock present always
// RULE_22 - Host rewinds pointer to fill row two
// RULE_23 - Reset clears pointer and subaddress counter
// RULE_24 - Bits placed MSB first, rows ascending per column
// RULE_25 - Pointer covers 0-31, wraps, bumps subaddress counter
`ifndef LSD_DEFINES_SVH
`define LSD_DEFINES_SVH

`define LSD_OFS_CTRL      8'h00
`define LSD_OFS_DPTR      8'h04
`define LSD_OFS_DEVSEL    8'h08
`define LSD_OFS_DATA      8'h0C
`define LSD_OFS_STATUS    8'h10

`define LSD_CTRL_MODE_LO  0
`define LSD_CTRL_MODE_HI  1
`define LSD_CTRL_EN_BIT   2

`define LSD_FRAME_DIV     5'h18
`define LSD_FRAME_LAST    5'h17
`define LSD_OSC_HALF_DEF  8

`define LSD_RST_PTR       5'h00
`define LSD_RST_SUB       3'h0
`define LSD_RST_EN        1'h0

`endif

// ---- lsd_pkg.sv ----
// Types shared by the LCD segment RAM and timing block.
// Assumes nothing of its surroundings.
package lsd_pkg;
  typedef enum logic [1:0] {
    LSD_STATIC,
    LSD_MUX2,
    LSD_MUX3,
    LSD_MUX4
  } lsd_mode_e;
endpackage

// ---- lsd_host.sv ----
// Host model: an AHB-Lite master issuing single word transfers for the bench.
// Assumes one slave whose hreadyout is fed back as hready.
`timescale 1ns/1ps
`default_nettype none
module lsd_host (
  input  wire logic        clk,    // Bus clock
  input  wire logic        hready, // Slave ready
  input  wire logic [31:0] hrdata, // Read data
  output logic             hsel,   // Select
  output logic [31:0]      haddr,  // Address
  output logic [1:0]       htrans, // Transfer type
  output logic             hwrite, // Write
  output logic [2:0]       hsize,  // Size, word only
  output logic [31:0]      hwdata  // Write data
);
  initial begin
    hsel = 1'h0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'h0;
    hsize = 3'h2;
    hwdata = 32'h0;
  end

  // Address phase held until hready is seen, then data phase held the same way
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] r);
    @(posedge clk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hsize <= 3'h2;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    hsel <= 1'h0;
    htrans <= 2'h0;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'h1) @(posedge clk);
    r = hrdata;
  endtask
endmodule
`default_nettype wire

// ---- lcd_segment_ram_and_timing_tb.sv ----
// Self-checking bench for the LCD segment RAM and timing block.
// Assumes the package, the design and lsd_host.sv are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "lsd_defines.svh"
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %s expected %0h seen %0h", n, e, a); end end
module lcd_segment_ram_and_timing_tb;
  logic        ref_clk = 1'h0;
  logic        rstn = 1'h0;
  logic        osc_sel = 1'h0;
  logic        ext_clk = 1'h0;
  logic [1:0]  dv = 2'h0;
  logic [2:0]  hw_sub = 3'h0;
  logic        sync_pull = 1'h0;
  logic        hsel, hwrite, hreadyout, hresp, clk_o, clk_oe_n, sync_o, sync_oe_n, ftick;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [31:0] haddr, hwdata, hrdata, seg, rd;
  logic [3:0]  bp;
  int          err_count = 0;
  int          cmp_count = 0;
  int          cyc = 0;
  // Shared lines: released clock follows the external source, released sync pulls up
  wire clk_line = clk_oe_n ? ext_clk : clk_o;
  wire sync_line = sync_oe_n ? ~sync_pull : sync_o;

  always #25 ref_clk = ~ref_clk;
  // External clock source: period of six system cycles
  always @(posedge ref_clk) begin
    dv <= (dv == 2'h2) ? 2'h0 : dv + 2'h1;
    if (dv == 2'h2) ext_clk <= ~ext_clk;
  end
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 30000) begin
      err_count++;
      end_of_test();
    end
  end

  lsd_host host (.clk(ref_clk), .hready(hreadyout), .hrdata(hrdata), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));

  lsd_seg_timing #(.OSC_HALF(2)) uut (.REF_CLK(ref_clk), .RSTN(rstn), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HREADYOUT(hreadyout), .HRDATA(hrdata), .HRESP(hresp),
    .OSC_SEL(osc_sel), .CLK_I(clk_line), .CLK_O(clk_o), .CLK_OE_N(clk_oe_n),
    .SYNC_I(sync_line), .SYNC_O(sync_o), .SYNC_OE_N(sync_oe_n), .HW_SUBADDR(hw_sub),
    .BP(bp), .SEG(seg), .FRAME_TICK(ftick));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    host.xfer(1'h1, {24'h0, a}, d, rd);
  endtask
  task automatic rdr(input logic [7:0] a);
    host.xfer(1'h0, {24'h0, a}, 32'h0, rd);
  endtask
  task automatic wait_bp(input logic [3:0] b);
    int n;
    n = 0;
    while (bp !== b && n < 500) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("bp_seen", b, bp)
  endtask
  task automatic frame_period(input int exp);
    int n;
    n = 0;
    @(posedge ref_clk);
    while (ftick !== 1'h1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    @(posedge ref_clk);
    n = 1;
    while (ftick !== 1'h1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("frame_period", exp, n)
  endtask

  task automatic t_reset();
    `CHK("hreadyout", 1'h1, hreadyout)
    `CHK("bp_off", 4'h0, bp)
    `CHK("hresp", 1'h0, hresp)
    rdr(`LSD_OFS_STATUS);
    `CHK("status_pins", 4'h0, rd[3:0])
    rdr(`LSD_OFS_DPTR);
    `CHK("ptr_reset", 32'h0, rd)
    rdr(`LSD_OFS_DEVSEL);
    `CHK("sub_reset", 32'h0, rd)
    rdr(8'h14);
    `CHK("unmapped", 32'h0, rd)
    `CHK("clk_drive", 1'h0, clk_oe_n)
  endtask
  task automatic t_ptr();
    int inc [4] = '{8, 4, 3, 2};
    for (int m = 0; m < 4; m++) begin
      wr(`LSD_OFS_CTRL, 32'(m));
      wr(`LSD_OFS_DPTR, 32'h5);
      wr(`LSD_OFS_DATA, 32'h0);
      rdr(`LSD_OFS_DPTR);
      `CHK("ptr_step", 32'(5 + inc[m]), rd)
    end
  endtask
  task automatic t_wrap();
    wr(`LSD_OFS_CTRL, 32'h3);
    wr(`LSD_OFS_DEVSEL, 32'h7);
    wr(`LSD_OFS_DPTR, 32'h1E);
    wr(`LSD_OFS_DATA, 32'hFF);
    rdr(`LSD_OFS_DPTR);
    `CHK("ptr_wrap", 32'h0, rd)
    rdr(`LSD_OFS_DEVSEL);
    `CHK("sub_bump", 32'h0, rd)
  endtask
  task automatic t_store4();
    wr(`LSD_OFS_DPTR, 32'h0);
    wr(`LSD_OFS_DATA, 32'hA5);
    wr(`LSD_OFS_CTRL, 32'h7);
    for (int r = 0; r < 4; r++) begin
      wait_bp(4'(1 << r));
      `CHK("seg_rows", (r % 2) ? 2'h2 : 2'h1, seg[1:0])
      `CHK("seg_inhibit", 1'h0, seg[30])
    end
  endtask
  task automatic t_mux3();
    wr(`LSD_OFS_CTRL, 32'h3);
    wr(`LSD_OFS_DPTR, 32'h2);
    wr(`LSD_OFS_DATA, 32'h30);
    wr(`LSD_OFS_CTRL, 32'h2);
    wr(`LSD_OFS_DPTR, 32'h0);
    wr(`LSD_OFS_DATA, 32'h0);
    wr(`LSD_OFS_CTRL, 32'h7);
    wait_bp(4'h8);
    `CHK("row3_kept", 4'h6, seg[3:0])
    wait_bp(4'h4);
    `CHK("row2_kept", 4'h4, seg[3:0])
    wr(`LSD_OFS_CTRL, 32'h2);
    wr(`LSD_OFS_DPTR, 32'h2);
    wr(`LSD_OFS_DATA, 32'h0);
    wr(`LSD_OFS_CTRL, 32'h7);
    wait_bp(4'h4);
    `CHK("row2_fill", 4'h0, seg[3:0])
  endtask
  task automatic t_static();
    wr(`LSD_OFS_CTRL, 32'h0);
    wr(`LSD_OFS_DPTR, 32'h0);
    wr(`LSD_OFS_DATA, 32'hC5);
    wr(`LSD_OFS_CTRL, 32'h4);
    wait_bp(4'hF);
    `CHK("static_row0", 8'hA3, seg[7:0])
  endtask
  task automatic t_dup();
    logic bad;
    logic seen;
    for (int m = 0; m < 4; m++) begin
      wr(`LSD_OFS_CTRL, 32'(4 + m));
      // First output edge after the write still shows the old mode
      @(posedge ref_clk);
      bad = 1'h0;
      seen = 1'h0;
      repeat (150) begin
        @(posedge ref_clk);
        seen = seen | (|bp);
        case (m)
          0: bad = bad | ~((&bp) | ~(|bp));
          1: bad = bad | (bp[2] !== bp[0]) | (bp[3] !== bp[1]);
          2: bad = bad | (bp[3] !== bp[1]);
          default: bad = bad | (bp[3] & bp[1]);
        endcase
      end
      `CHK("bp_dup", 2'h1, {bad, seen})
    end
  endtask
  task automatic t_clock();
    frame_period(96);
    `CHK("sync_low", 1'h0, sync_o)
    @(posedge ref_clk);
    `CHK("sync_drive", 1'h0, sync_oe_n)
    osc_sel <= 1'h1;
    repeat (8) @(posedge ref_clk);
    `CHK("clk_release", 1'h1, clk_oe_n)
    frame_period(144);
  endtask
  // A foreign device pulls sync low mid-frame: our next frame end moves to 24 ticks later
  task automatic t_sync();
    int n;
    repeat (60) @(posedge ref_clk);
    sync_pull <= 1'h1;
    @(posedge ref_clk);
    sync_pull <= 1'h0;
    n = 1;
    while (ftick !== 1'h1 && n < 1000) begin
      @(posedge ref_clk);
      n++;
    end
    `CHK("sync_realign", 1'h1, n >= 143 && n <= 148)
  endtask

  task automatic end_of_test();
    $display("errors %0d comparisons %0d", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    repeat (20) @(posedge ref_clk);
    rstn <= 1'h1;
    repeat (4) @(posedge ref_clk);
    t_reset();
    t_ptr();
    t_wrap();
    t_store4();
    t_mux3();
    t_static();
    t_dup();
    t_clock();
    t_sync();
    end_of_test();
  end
endmodule
`default_nettype wire
